// ---- design/ahg_host_glue.sv ----
/*
  Host-side glue between a processor bus (I/O port, data-memory read, DMA)
  and an asynchronous sampling converter's parallel pins.
  Assumes converter pins are asynchronous to core_clk and the requester
  holds its request until the ready or acknowledge it waits for.
*/
// Function
// - A write to the data port starts a conversion.
// - Status and result are read from the converter's assigned ports.
// - Every converter access is stretched by a wait state from decode.
// - After each read the host leaves one idle cycle before the next.
// - Each conversion-done sets a latched DMA request on channel 1.
// - The following DMA read of the result clears that request.
// - The DMA channel is serviced before the next conversion completes.
// - A data-memory read at the decoded address drives output enable.
// - Memory acknowledge comes five cycles after decode, within 160 ns in total.
// - A host with a built-in I/O wait state needs no more wait logic.
// - Status and result sit at distinct port addresses.
// - Chip select falls before output enable; data is valid under both.
// - No converter access is made within 10 us of power-up.
`timescale 1ns/10ps
`include "ahg_cfg.svh"
module ahg_host_glue (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ioStrobe_n,
  input wire logic microstateComplete_n,
  input wire logic [`AHG_ADDR_W-1:0] busAddr,
  input wire logic busRead,
  input wire logic busWrite,
  input wire logic dataMemRead,
  input wire logic [`AHG_MEM_ADDR_W-1:0] dataMemAddr,
  input wire logic dmaRead,
  input wire logic bipolarMode,
  output logic busReady,
  output logic memoryAcknowledge,
  output logic [`AHG_BUS_W-1:0] busRdData,
  output logic dmaRequestCh1,
  output logic convIrq,
  output logic powerUpDone,
  output logic convStart_n,
  output logic chipSelect_n,
  output logic outputEnable_n,
  input wire logic convDone,
  input wire logic [`AHG_RES_W-1:0] resultBits
);

  ahg_pkg::ahg_state_t state_r, state_nxt;
  ahg_pkg::ahg_src_t src_r, src_nxt;
  logic [`AHG_PWRUP_W-1:0] pwrCnt_r;
  logic [`AHG_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [`AHG_SYNC_W-1:0] pinSync;
  logic doneSync, doneSyncD_r, doneRise;
  logic dmaReq_r, dmaClr;
  logic [`AHG_BUS_W-1:0] rdData_r, rdData_nxt;
  logic idle;

  ahg_sync #(.W(`AHG_SYNC_W)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async({convDone, resultBits}),
    .synced(pinSync)
  );

  // Conversion-done is only trusted after the two-stage synchroniser.
  assign doneSync = pinSync[`AHG_SYNC_DONE_BIT];
  assign doneRise = doneSync & ~doneSyncD_r;
  assign convIrq = doneSync;

  // Port decode qualified by strobe and microstate complete.
  wire ioCycle = ~ioStrobe_n & ~microstateComplete_n;
  wire hitData = busAddr == `AHG_PORT_DATA;
  wire hitStatus = busAddr == `AHG_PORT_STATUS;
  wire ioStart = ioCycle & busWrite & hitData;
  wire ioStatus = ioCycle & busRead & hitStatus;
  wire ioData = ioCycle & busRead & hitData;
  wire memHit = dataMemRead & (dataMemAddr == `AHG_MEM_ADDR);
  wire anyRead = ioData | memHit | dmaRead;

  // Sign or zero extension of the 14-bit code onto the 16-bit bus.
  wire [`AHG_RES_W-1:0] res = pinSync[`AHG_RES_W-1:0];
  wire extBit = bipolarMode & res[`AHG_RES_W-1];
  wire [`AHG_BUS_W-1:0] resExt = {{2{extBit}}, res};
  wire [`AHG_BUS_W-1:0] statusWord = {15'h0000, doneSync};

  assign idle = state_r == ahg_pkg::ST_IDLE;
  wire inDone = state_r == ahg_pkg::ST_DONE;
  assign dmaClr = inDone & (src_r == ahg_pkg::SRC_DMA);

  always_comb begin
    state_nxt = state_r;
    src_nxt = src_r;
    cnt_nxt = cnt_r;
    rdData_nxt = rdData_r;
    case (state_r)
      ahg_pkg::ST_PWRUP: begin
        // Accesses are held off until the converter has reset itself.
        if (pwrCnt_r == `AHG_PWRUP_W'(`AHG_PWRUP_CYC - 1)) begin
          state_nxt = ahg_pkg::ST_IDLE;
        end
      end
      ahg_pkg::ST_IDLE: begin
        cnt_nxt = '0;
        if (ioStart) begin
          src_nxt = ahg_pkg::SRC_IO;
          state_nxt = ahg_pkg::ST_START;
        end else if (ioStatus) begin
          src_nxt = ahg_pkg::SRC_IO;
          rdData_nxt = statusWord;
          state_nxt = ahg_pkg::ST_DONE;
        end else if (anyRead) begin
          if (dmaRead) begin
            src_nxt = ahg_pkg::SRC_DMA;
          end else if (memHit) begin
            src_nxt = ahg_pkg::SRC_MEM;
          end else begin
            src_nxt = ahg_pkg::SRC_IO;
          end
          state_nxt = ahg_pkg::ST_CS;
        end
      end
      ahg_pkg::ST_START: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == `AHG_CNT_W'(`AHG_START_CYC - 1)) begin
          state_nxt = ahg_pkg::ST_DONE;
        end
      end
      ahg_pkg::ST_CS: begin
        state_nxt = ahg_pkg::ST_OE;
      end
      ahg_pkg::ST_OE: begin
        // Data needs two synchroniser cycles after enable before capture.
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == `AHG_CNT_W'(`AHG_OE_CYC - 1)) begin
          rdData_nxt = resExt;
          state_nxt = ahg_pkg::ST_DONE;
        end
      end
      ahg_pkg::ST_DONE: begin
        state_nxt = ahg_pkg::ST_RECOVER;
      end
      ahg_pkg::ST_RECOVER: begin
        state_nxt = ahg_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = ahg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ahg_pkg::ST_PWRUP;
      src_r <= ahg_pkg::SRC_IO;
      cnt_r <= '0;
      rdData_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      src_r <= src_nxt;
      cnt_r <= cnt_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwrCnt_r <= '0;
    end else if (state_r == ahg_pkg::ST_PWRUP) begin
      pwrCnt_r <= pwrCnt_r + 1'b1;
    end
  end

  // A new conversion-done in the clearing cycle keeps the request set.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      doneSyncD_r <= 1'b0;
      dmaReq_r <= 1'b0;
    end else begin
      doneSyncD_r <= doneSync;
      dmaReq_r <= doneRise | (dmaReq_r & ~dmaClr);
    end
  end

  assign dmaRequestCh1 = dmaReq_r;
  assign powerUpDone = state_r != ahg_pkg::ST_PWRUP;
  assign busRdData = rdData_r;
  assign busReady = inDone & (src_r != ahg_pkg::SRC_MEM);
  assign memoryAcknowledge = inDone & (src_r == ahg_pkg::SRC_MEM);
  assign convStart_n = state_r != ahg_pkg::ST_START;
  assign chipSelect_n = ~(state_r == ahg_pkg::ST_CS
                        || state_r == ahg_pkg::ST_OE);
  assign outputEnable_n = state_r != ahg_pkg::ST_OE;

  localparam int MemMaxCyc = `AHG_MEM_READ_CYC;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_start_pulse;
    $fell(convStart_n) |-> !convStart_n[*4] ##1 convStart_n;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("Start pulse has wrong width.");

  property p_status_wait;
    idle && ioStatus && !ioStart |=> busReady ##1 !busReady;
  endproperty
  a_status_wait: assert property (p_status_wait)
    else $error("Status read not answered after one wait state.");

  property p_recover;
    (busReady || memoryAcknowledge) |=> !busReady && !memoryAcknowledge
      ##1 !busReady && !memoryAcknowledge;
  endproperty
  a_recover: assert property (p_recover)
    else $error("No idle cycle after an access.");

  property p_dma_set;
    doneRise |=> dmaRequestCh1;
  endproperty
  a_dma_set: assert property (p_dma_set)
    else $error("Conversion-done did not raise the DMA request.");

  property p_dma_clr;
    dmaClr && !doneRise |=> !dmaRequestCh1;
  endproperty
  a_dma_clr: assert property (p_dma_clr)
    else $error("DMA read did not clear the request.");

  property p_mem_ack;
    idle && memHit && !ioStart && !ioStatus && !dmaRead && !ioData
      |-> ##[1:MemMaxCyc] memoryAcknowledge;
  endproperty
  a_mem_ack: assert property (p_mem_ack)
    else $error("Memory read not acknowledged within 160 ns.");

  property p_cs_first;
    $fell(outputEnable_n) |-> !$past(chipSelect_n) && !chipSelect_n;
  endproperty
  a_cs_first: assert property (p_cs_first)
    else $error("Output enable fell without chip select low before.");

  property p_pwrup;
    !powerUpDone |-> convStart_n && chipSelect_n && !busReady
      && !memoryAcknowledge;
  endproperty
  a_pwrup: assert property (p_pwrup)
    else $error("Converter accessed during power-up wait.");

  property p_sync;
    $rose(dmaRequestCh1) |-> $past(doneSync) && !$past(doneSyncD_r);
  endproperty
  a_sync: assert property (p_sync)
    else $error("DMA request set without synchronised edge.");

  c_status: cover property (idle && ioStatus ##1 busReady);
  c_io_data: cover property (busReady && src_r == ahg_pkg::SRC_IO
    && $past(state_r) == ahg_pkg::ST_OE);
  c_dma: cover property (dmaClr);
  c_mem: cover property (memoryAcknowledge);

endmodule : ahg_host_glue

// ---- design/ahg_cfg.svh ----
/*
  Constants for the converter host glue: port addresses, field positions,
  widths and timing counts.
  Assumes a 125 MHz core clock; included by bare name.
*/
`ifndef AHG_CFG_SVH
`define AHG_CFG_SVH

`define AHG_CLK_NS 8
`define AHG_ADDR_W 8
`define AHG_PORT_DATA 8'h01
`define AHG_PORT_STATUS 8'h02
`define AHG_MEM_ADDR_W 16
`define AHG_MEM_ADDR 16'hC000
`define AHG_RES_W 14
`define AHG_BUS_W 16
`define AHG_STATUS_DONE_BIT 0
`define AHG_SYNC_W 15
`define AHG_SYNC_DONE_BIT 14
`define AHG_PWRUP_NS 10000
`define AHG_PWRUP_CYC ((`AHG_PWRUP_NS + `AHG_CLK_NS - 1) / `AHG_CLK_NS)
`define AHG_PWRUP_W 11
`define AHG_START_CYC 4
`define AHG_OE_CYC 3
`define AHG_CNT_W 3
`define AHG_MEM_READ_NS 160
`define AHG_MEM_READ_CYC (`AHG_MEM_READ_NS / `AHG_CLK_NS)

`endif

// ---- design/ahg_pkg.sv ----
/*
  Types for the converter host glue: access states and requester kinds.
  Assumes the constants of ahg_cfg.svh.
*/
package ahg_pkg;

  typedef enum logic [2:0] {
    ST_PWRUP = 3'h0,
    ST_IDLE = 3'h1,
    ST_START = 3'h2,
    ST_CS = 3'h3,
    ST_OE = 3'h4,
    ST_DONE = 3'h5,
    ST_RECOVER = 3'h6
  } ahg_state_t;

  typedef enum logic [1:0] {
    SRC_IO = 2'h0,
    SRC_MEM = 2'h1,
    SRC_DMA = 2'h2
  } ahg_src_t;

endpackage : ahg_pkg

// ---- design/ahg_sync.sv ----
/*
  Two flip-flop synchroniser, one generate branch per bit.
  Assumes every bit comes from a pin outside the core clock domain.
*/
`timescale 1ns/10ps
module ahg_sync #(
  parameter int W = 15
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);

  logic [W-1:0] stage1_r;

  // The first stage feeds only the second stage.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        stage1_r[i] <= 1'b0;
        synced[i] <= 1'b0;
      end else begin
        stage1_r[i] <= async[i];
        synced[i] <= stage1_r[i];
      end
    end
  end

endmodule : ahg_sync

// ---- testbench/ahg_conv_model.sv ----
/*
  Behavioural model of the sampling converter on the glue's far side.
  Assumes the bench supplies the output code and an external trigger.
*/
`timescale 1ns/10ps
module ahg_conv_model #(
  parameter int CONV_NS = 601
) (
  input wire logic chipSelect_n,
  input wire logic outputEnable_n,
  input wire logic convStart_n,
  input wire logic trig,
  input wire logic [13:0] code,
  output logic convDone,
  output logic [13:0] resultBits
);
  initial convDone = 1'b0;
  // A start pin or a trigger unrelated to the host clock may begin it.
  always @(negedge convStart_n or posedge trig) begin
    convDone = 1'b0;
    #CONV_NS convDone = 1'b1;
  end
  // Undriven pins show the inverted code so a stale sample cannot match.
  // The odd conversion time keeps the done edge off the host clock edge.
  assign resultBits = (!chipSelect_n && !outputEnable_n) ? code
                      : ~code;
endmodule : ahg_conv_model

// ---- testbench/tb.sv ----
/*
  Self-checking bench for the converter host glue.
  Assumes the glue's port walk and the converter model beside it.
*/
`timescale 1ns/10ps
`include "ahg_cfg.svh"
module tb;
  logic core_clk, rst, ioStrobe_n, microstateComplete_n, busRead, busWrite;
  logic dataMemRead, dmaRead, bipolarMode, trig, busReady, memoryAcknowledge;
  logic dmaRequestCh1, convIrq, powerUpDone, convStart_n, chipSelect_n;
  logic outputEnable_n, convDone;
  logic [`AHG_ADDR_W-1:0] busAddr;
  logic [`AHG_MEM_ADDR_W-1:0] dataMemAddr;
  logic [`AHG_BUS_W-1:0] busRdData, d;
  logic [`AHG_RES_W-1:0] resultBits, code;
  int miscompares = 0, testsRun = 0, cyc = 0, stLow = 0, n;
  ahg_host_glue ahg_host_glue_i (.core_clk, .rst, .ioStrobe_n,
    .microstateComplete_n, .busAddr, .busRead, .busWrite, .dataMemRead,
    .dataMemAddr, .dmaRead, .bipolarMode, .busReady, .memoryAcknowledge,
    .busRdData, .dmaRequestCh1, .convIrq, .powerUpDone, .convStart_n,
    .chipSelect_n, .outputEnable_n, .convDone, .resultBits);
  ahg_conv_model ahg_conv_model_i (.chipSelect_n, .outputEnable_n,
    .convStart_n, .trig, .code, .convDone, .resultBits);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // Kind 0 is an I/O write, 1 an I/O read, 2 a DMA read, 3 a memory read.
  task automatic acc(input int k, input logic [15:0] a, output int m,
                     output logic [15:0] q);
    logic seen;
    seen = 1'b0;
    m = 0;
    @(posedge core_clk);
    ioStrobe_n <= (k > 1);
    microstateComplete_n <= (k > 1);
    busWrite <= (k == 0);
    busRead <= (k == 1);
    dmaRead <= (k == 2);
    dataMemRead <= (k == 3);
    busAddr <= a[7:0];
    dataMemAddr <= a;
    while (!seen && m < 40) begin
      @(posedge core_clk);
      m++;
      seen = (k == 3) ? (memoryAcknowledge === 1'b1) : (busReady === 1'b1);
    end
    q = busRdData;
    ioStrobe_n <= 1'b1;
    microstateComplete_n <= 1'b1;
    {busWrite, busRead, dmaRead, dataMemRead} <= 4'h0;
  endtask : acc
  // The request must trail the done pin by the synchroniser's depth.
  task automatic waitReq;
    int m;
    m = 0;
    while (convDone !== 1'b1 && m < 300) begin
      @(posedge core_clk);
      m++;
    end
    m = 0;
    while (dmaRequestCh1 !== 1'b1 && m < 20) begin
      @(posedge core_clk);
      m++;
    end
    chk(m >= 2 && m <= 5, 16'h0001);
    chk(convIrq, 16'h0001);
  endtask : waitReq
  always @(posedge core_clk) begin
    cyc++;
    if (convStart_n === 1'b0)
      stLow++;
    if (cyc == 6000) begin
      miscompares++;
      conclude();
    end
  end
  always @(negedge outputEnable_n) chk(chipSelect_n, 16'h0000);
  task automatic t_power;
    chk({dmaRequestCh1, busReady, chipSelect_n, outputEnable_n, convStart_n},
        16'h0007);
    @(posedge core_clk);
    rst <= 1'b0;
    n = 0;
    while (powerUpDone !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    chk(n >= 1245 && n <= 1255, 16'h0001);
  endtask : t_power
  task automatic t_start;
    stLow = 0;
    acc(0, 16'h0001, n, d);
    chk(n, 16'h0006);
    chk(stLow, 16'h0004);
    waitReq();
    acc(1, 16'h0002, n, d);
    chk(n, 16'h0002);
    chk(d, 16'h0001);
  endtask : t_start
  task automatic t_reads;
    for (int i = 0; i < 2; i++) begin
      bipolarMode <= i[0];
      code <= 14'h2001;
      acc(1, 16'h0001, n, d);
      chk(n, 16'h0006);
      chk(d, i ? 16'hE001 : 16'h2001);
    end
    chk(dmaRequestCh1, 16'h0001);
    acc(2, 16'h0000, n, d);
    chk(n, 16'h0006);
    chk(d, 16'hE001);
    @(posedge core_clk);
    chk(dmaRequestCh1, 16'h0000);
    code <= 14'h0155;
    acc(3, 16'hC000, n, d);
    chk(n, 16'h0006);
    chk(d, 16'h0155);
    acc(3, 16'hC001, n, d);
    chk(n, 16'h0028);
    acc(0, 16'h0003, n, d);
    chk(n, 16'h0028);
  endtask : t_reads
  task automatic t_trig;
    trig <= 1'b1;
    @(posedge core_clk);
    trig <= 1'b0;
    waitReq();
  endtask : t_trig
  initial begin
    {rst, ioStrobe_n, microstateComplete_n} = 3'h7;
    {busRead, busWrite, dataMemRead, dmaRead, bipolarMode, trig} = 6'h00;
    busAddr = 8'h00;
    dataMemAddr = 16'h0000;
    code = 14'h0000;
    repeat (10) @(posedge core_clk);
    t_power();
    t_start();
    t_reads();
    t_trig();
    conclude();
  end
endmodule : tb
